// >>> pkg/amtg_pkg.sv
/*
 * Shared constants and carriers for the memory ingress router: register map,
 * field positions, reset values, queue depth and the command and route structs.
 * Assumes one clock domain and a register bus of AXI4-Lite with 32-bit data.
 */
package amtg_pkg;

  localparam int ADDR_W = 33;
  localparam int TAG_W = 6;
  localparam int LEN_W = 4;
  localparam int PORT_W = 4;
  localparam int BURST_LSB = 5;
  localparam int Q_DEPTH = 12;
  localparam int CNT_W = 4;

  localparam logic [CNT_W-1:0] Q_DEPTH_C = 4'hC;

  // Register byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ISSUED = 8'h08;
  localparam logic [7:0] REG_LAST_ROUTE = 8'h0C;

  // Control fields and reset value.
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int CTRL_REORDER_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Last route fields.
  localparam int ROUTE_PORT_LSB = 0;
  localparam int ROUTE_STACK_BIT = 4;
  localparam int ROUTE_SWITCH_BIT = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic write;
    logic [TAG_W-1:0] transaction_tag_field;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] len;
    logic [1:0] burst;
  } amtg_cmd_t;

  typedef struct packed {
    amtg_cmd_t cmd;
    logic stack;
    logic [PORT_W-1:0] port;
    logic via_switch;
  } amtg_route_t;

endpackage : amtg_pkg

// >>> core/amtg_ingress.sv
/*
 * Ingress port of the memory subsystem: takes commands from a traffic master,
 * holds them in a twelve-entry ordering queue, routes each one either through
 * the global switch or straight to the home pseudo channel, and exposes control
 * and status over AXI4-Lite.
 * Assumes the master keeps its own pacing and address rules, and that the
 * controller side accepts a routed command whenever mc_ready_in is high.
 */
`timescale 1ns/1ps
module amtg_ingress
  import amtg_pkg::*;
#(
  parameter logic HOME_STACK = 1'b0,
  parameter logic [PORT_W-1:0] HOME_PORT = 4'h0
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Command ingress from the traffic master.
  input wire logic cmd_valid_in,
  input wire amtg_cmd_t cmd_in,
  output logic cmd_ready_out,
  // Routed command toward the controller.
  output logic mc_valid_out,
  output amtg_route_t mc_route_out,
  input wire logic mc_ready_in,
  // AXI4-Lite register slave.
  input wire logic [7:0] s_awaddr_in,
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  output logic [1:0] s_bresp_out,
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  input wire logic [7:0] s_araddr_in,
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  output logic [31:0] s_rdata_out,
  output logic [1:0] s_rresp_out,
  output logic s_rvalid_out,
  input wire logic s_rready_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Ordering queue and routing.

  amtg_cmd_t q_reg [Q_DEPTH];
  amtg_cmd_t q_next [Q_DEPTH];
  logic [CNT_W-1:0] cnt_reg, cnt_next, cnt_mid;
  logic cmd_ready_reg, cmd_ready_next;
  logic mc_valid_reg, mc_valid_next;
  amtg_route_t mc_route_reg, mc_route_next;
  logic [31:0] issued_reg, issued_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic sel_found, take, accept, ok;
  logic [CNT_W-1:0] sel_idx;

  wire logic global_en = ctrl_reg[CTRL_GLOBAL_BIT];
  wire logic reorder_en = ctrl_reg[CTRL_REORDER_BIT];

  function automatic logic conflict(input amtg_cmd_t older, input amtg_cmd_t younger);
    logic same_tag;
    logic same_burst;
    same_tag = older.transaction_tag_field == younger.transaction_tag_field;
    same_burst = older.addr[ADDR_W-1:BURST_LSB] == younger.addr[ADDR_W-1:BURST_LSB];
    conflict = same_tag || (same_burst && (older.write != younger.write));
  endfunction : conflict

  always_comb begin
    sel_found = 1'b0;
    sel_idx = '0;
    ok = 1'b0;
    // The oldest eligible entry wins, so starvation is bounded by queue depth.
    for (int i = 0; i < Q_DEPTH; i++) begin
      if (!sel_found && (i < int'(cnt_reg))) begin
        ok = (i == 0) || reorder_en;
        for (int j = 0; j < Q_DEPTH; j++) begin
          if ((j < i) && conflict(q_reg[j], q_reg[i])) begin
            ok = 1'b0;
          end
        end
        if (ok) begin
          sel_found = 1'b1;
          sel_idx = CNT_W'(i);
        end
      end
    end
  end

  always_comb begin
    q_next = q_reg;
    take = sel_found && (!mc_valid_reg || mc_ready_in);
    accept = cmd_valid_in && cmd_ready_reg;
    mc_valid_next = mc_valid_reg && !mc_ready_in;
    mc_route_next = mc_route_reg;
    issued_next = issued_reg;
    cnt_mid = cnt_reg;
    if (take) begin
      for (int i = 0; i < Q_DEPTH - 1; i++) begin
        if (i >= int'(sel_idx)) begin
          q_next[i] = q_reg[i + 1];
        end
      end
      cnt_mid = cnt_reg - 4'h1;
      mc_valid_next = 1'b1;
      issued_next = issued_reg + 32'h1;
      mc_route_next.cmd = q_reg[sel_idx];
      if (global_en) begin
        mc_route_next.stack = q_reg[sel_idx].addr[ADDR_W-1];
        mc_route_next.port = q_reg[sel_idx].addr[ADDR_W-2 -: PORT_W];
        mc_route_next.via_switch = 1'b1;
      end else begin
        mc_route_next.stack = HOME_STACK;
        mc_route_next.port = HOME_PORT;
        mc_route_next.via_switch = 1'b0;
      end
    end
    if (accept) begin
      q_next[cnt_mid] = cmd_in;
    end
    cnt_next = cnt_mid + CNT_W'(accept);
    // Ready is registered, so it reflects the fill level after this edge.
    cmd_ready_next = cnt_next != Q_DEPTH_C;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < Q_DEPTH; i++) begin
        q_reg[i] <= '0;
      end
      cnt_reg <= '0;
      cmd_ready_reg <= 1'b0;
      mc_valid_reg <= 1'b0;
      mc_route_reg <= '0;
      issued_reg <= '0;
    end else begin
      q_reg <= q_next;
      cnt_reg <= cnt_next;
      cmd_ready_reg <= cmd_ready_next;
      mc_valid_reg <= mc_valid_next;
      mc_route_reg <= mc_route_next;
      issued_reg <= issued_next;
    end
  end

  assign cmd_ready_out = cmd_ready_reg;
  assign mc_valid_out = mc_valid_reg;
  assign mc_route_out = mc_route_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic aw_take, w_take, ar_take, do_write;
  logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;

  always_comb begin
    aw_take = s_awvalid_in && !aw_held_reg && !bvalid_reg;
    w_take = s_wvalid_in && !w_held_reg && !bvalid_reg;
    ar_take = s_arvalid_in && !rvalid_reg;
    aw_held_next = aw_held_reg || aw_take;
    w_held_next = w_held_reg || w_take;
    awaddr_next = aw_take ? s_awaddr_in : awaddr_reg;
    wdata_next = w_take ? s_wdata_in : wdata_reg;
    wstrb_next = w_take ? s_wstrb_in : wstrb_reg;
    do_write = aw_held_reg && w_held_reg;
    bvalid_next = bvalid_reg && !s_bready_in;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (awaddr_reg == REG_CTRL) begin
        if (wstrb_reg[0]) begin
          ctrl_next = wdata_reg[1:0];
        end
      end else if (awaddr_reg != REG_STATUS && awaddr_reg != REG_ISSUED
                   && awaddr_reg != REG_LAST_ROUTE) begin
        bresp_next = RESP_SLVERR;
      end
    end
    rvalid_next = rvalid_reg && !s_rready_in;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_take) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      unique case (s_araddr_in)
        REG_CTRL: rdata_next = {30'h0, ctrl_reg};
        REG_STATUS: rdata_next = {28'h0, cnt_reg};
        REG_ISSUED: rdata_next = issued_reg;
        REG_LAST_ROUTE: rdata_next = {26'h0, mc_route_reg.via_switch,
                                      mc_route_reg.stack, mc_route_reg.port};
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    // Readies are registered from the next state, so they match the held flags each cycle.
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ctrl_reg <= ctrl_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
    end
  end

  // Every bus output is a flop, so no combinational path reaches the pins.
  assign s_awready_out = awready_reg;
  assign s_wready_out = wready_reg;
  assign s_arready_out = arready_reg;
  assign s_bvalid_out = bvalid_reg;
  assign s_bresp_out = bresp_reg;
  assign s_rvalid_out = rvalid_reg;
  assign s_rdata_out = rdata_reg;
  assign s_rresp_out = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_stack_sel;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (take && global_en) |=> (mc_route_out.stack == mc_route_out.cmd.addr[ADDR_W-1]);
  endproperty
  a_stack_sel: assert property (p_stack_sel) else $error("Stack select mismatch.");

  property p_port_sel;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (take && global_en) |=> (mc_route_out.via_switch
      && mc_route_out.port == mc_route_out.cmd.addr[ADDR_W-2 -: PORT_W]);
  endproperty
  a_port_sel: assert property (p_port_sel) else $error("Switch port mismatch.");

  property p_bypass;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (take && !global_en) |=> (!mc_route_out.via_switch && mc_route_out.port == HOME_PORT
      && mc_route_out.stack == HOME_STACK);
  endproperty
  a_bypass: assert property (p_bypass) else $error("Bypass route wrong.");

  property p_head_only;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (take && !reorder_en) |-> (sel_idx == 4'h0)
      ##1 (mc_valid_out && mc_route_out.cmd == $past(q_reg[0]));
  endproperty
  a_head_only: assert property (p_head_only) else $error("Out of order issue.");

  property p_no_overtake;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (take && sel_idx != 4'h0) |-> (reorder_en && !conflict(q_reg[0], q_reg[sel_idx]));
  endproperty
  a_no_overtake: assert property (p_no_overtake) else $error("Dependency overtaken.");

  property p_full_stall;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cnt_reg == Q_DEPTH_C) |-> !cmd_ready_out;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("Ready while full.");

  property p_write_resp;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (aw_held_reg && w_held_reg) |=> s_bvalid_out && !s_awready_out;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("Missing write response.");

  property p_read_resp;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (s_arvalid_in && s_arready_out) |=> s_rvalid_out [*1] ##0 !s_arready_out;
  endproperty
  a_read_resp: assert property (p_read_resp) else $error("Missing read data.");

endmodule : amtg_ingress

// >>> tb/amtg_master_model.sv
/*
 * Behavioural traffic master that feeds the ingress command port.
 * Assumes the bench hands it a fresh random word on rnd_in every cycle.
 */
`timescale 1ns/1ps
module amtg_master_model
  import amtg_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Command programming.
  input wire logic go_in,
  input wire logic [7:0] count_in,
  input wire logic [ADDR_W-1:0] start_in,
  input wire logic [ADDR_W-1:0] step_in,
  input wire logic [ADDR_W-1:0] base_in,
  input wire logic [ADDR_W-1:0] high_in,
  input wire logic rand_in,
  input wire logic unal_in,
  input wire logic tag_inc_in,
  input wire logic [1:0] gap_in,
  input wire logic [31:0] rnd_in,
  // Command port.
  input wire logic cmd_ready_in,
  output logic cmd_valid_out,
  output amtg_cmd_t cmd_out,
  output logic busy_out
);
  logic [ADDR_W-1:0] addr;
  logic [TAG_W-1:0] tag;
  amtg_cmd_t c;
  ////////////////////////////////////////
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
    busy_out = 1'b0;
    tag = '0;
    forever begin
      @(posedge core_clk_in);
      if (go_in && rst_n_in) begin
        busy_out <= 1'b1;
        addr = start_in;
        repeat (gap_in) @(posedge core_clk_in);
        for (int n = 0; n < count_in; n++) begin
          // Beats are always 32 bytes, size code five; the carrier leaves it implicit.
          c.write = rnd_in[0];
          c.transaction_tag_field = tag;
          c.addr = addr;
          c.len = rnd_in[4:1];
          c.burst = rnd_in[5] ? 2'h1 : 2'h2;
          cmd_valid_out <= 1'b1;
          cmd_out <= c;
          do @(posedge core_clk_in); while (cmd_ready_in !== 1'b1);
          if (tag_inc_in) tag = tag + 1'b1;
          // With unal_in in random mode, addresses after the first sit half a burst past a boundary unless wrapped to base_in.
          if (rand_in) addr = base_in + ((rnd_in % (high_in - base_in)) & ~33'h1F)
                              + (unal_in ? 33'h10 : 33'h0);
          else addr = addr + step_in;
          if (addr >= high_in) addr = base_in;
          if (gap_in != 2'h0) begin
            cmd_valid_out <= 1'b0;
            repeat (gap_in) @(posedge core_clk_in);
          end
        end
        cmd_valid_out <= 1'b0;
        busy_out <= 1'b0;
      end
    end
  end
endmodule : amtg_master_model

// >>> tb/tb_top.sv
/*
 * Self-checking bench: master model traffic, AXI4-Lite register access and a
 * queue model that judges every routed command.
 * Assumes the register map and queue depth of the package.
 */
`timescale 1ns/1ps
module tb_top import amtg_pkg::*;;
  localparam logic H_STACK = 1'b1;
  localparam logic [PORT_W-1:0] H_PORT = 4'h9;
  logic core_clk_in, rst_n_in, cmd_valid_in, cmd_ready_out, mc_valid_out, mc_ready_in;
  amtg_cmd_t cmd_in;
  amtg_route_t mc_route_out;
  logic [7:0] awaddr, araddr, cnt;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [31:0] lfsr_q = 32'h66760936;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, gap, ctrl_q;
  logic go, busy, rnd_mode, tag_inc, mc_en, unal;
  logic [ADDR_W-1:0] st, stp, bs, hi;
  logic [5:0] last_q;
  int num_errors, total_checks, n_iss;
  amtg_cmd_t q[$];
  ////////////////////////////////////////
  amtg_ingress #(.HOME_STACK(H_STACK), .HOME_PORT(H_PORT)) dut_u (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .mc_valid_out(mc_valid_out),
    .mc_route_out(mc_route_out), .mc_ready_in(mc_ready_in), .s_awaddr_in(awaddr),
    .s_awvalid_in(awvalid), .s_awready_out(awready), .s_wdata_in(wdata), .s_wstrb_in(wstrb),
    .s_wvalid_in(wvalid), .s_wready_out(wready), .s_bresp_out(bresp), .s_bvalid_out(bvalid),
    .s_bready_in(bready), .s_araddr_in(araddr), .s_arvalid_in(arvalid),
    .s_arready_out(arready), .s_rdata_out(rdata), .s_rresp_out(rresp),
    .s_rvalid_out(rvalid), .s_rready_in(rready));
  amtg_master_model mst_u (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .go_in(go), .count_in(cnt),
    .start_in(st), .step_in(stp), .base_in(bs), .high_in(hi), .rand_in(rnd_mode),
    .tag_inc_in(tag_inc), .gap_in(gap), .rnd_in(lfsr_q), .unal_in(unal),
    .cmd_ready_in(cmd_ready_out),
    .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in), .busy_out(busy));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [63:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk
  task automatic finish_test();
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_in);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    fork
      begin
        do @(posedge core_clk_in); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge core_clk_in); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge core_clk_in); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_in);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge core_clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk_in); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic run(input logic [7:0] n, input logic [ADDR_W-1:0] a, s, b, h,
                     input logic rm, ti, input logic [1:0] g);
    @(posedge core_clk_in);
    {cnt, st, stp, bs, hi, rnd_mode, tag_inc, gap, go} <= {n, a, s, b, h, rm, ti, g, 1'b1};
    @(posedge core_clk_in);
    go <= 1'b0;
    do @(posedge core_clk_in); while (busy);
    while (q.size() != 0 || mc_valid_out) @(posedge core_clk_in);
  endtask : run
  // A routed command must be an entry not held back by an older one of the same tag or by an
  // opposite-direction access to the same burst; with reordering off, the oldest.
  task automatic issue_chk();
    amtg_cmd_t c;
    int k;
    logic ok;
    c = mc_route_out.cmd;
    k = -1;
    foreach (q[i]) if (k < 0 && q[i] === c) k = i;
    ok = (k == 0) || (k > 0 && ctrl_q[1]);
    for (int i = 0; i < k; i++) begin
      if (q[i].transaction_tag_field === c.transaction_tag_field) ok = 1'b0;
      if (q[i].write !== c.write && q[i].addr[32:5] === c.addr[32:5]) ok = 1'b0;
    end
    chk(ok, 1'b1, "issue order");
    last_q = ctrl_q[0] ? {1'b1, c.addr[32], c.addr[31:28]} : {1'b0, H_STACK, H_PORT};
    chk({mc_route_out.via_switch, mc_route_out.stack, mc_route_out.port}, last_q, "route");
    if (k >= 0) q.delete(k);
    n_iss++;
  endtask : issue_chk
  ////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    lfsr_q <= lfsr(lfsr_q);
    mc_ready_in <= mc_en & lfsr_q[3];
    if (rst_n_in && mc_valid_out && mc_ready_in) issue_chk();
    if (rst_n_in && cmd_valid_in && cmd_ready_out) q.push_back(cmd_in);
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    num_errors++;
    finish_test();
  end
  initial begin
    {rst_n_in, go, mc_en, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, cnt, st, stp, bs, hi, rnd_mode, tag_inc, gap, ctrl_q, unal} = '0;
    wstrb = 4'hF;
    {num_errors, total_checks, n_iss} = '0;
    repeat (20) @(posedge core_clk_in);
    chk(cmd_ready_out, 1'b0, "ready in reset");
    rst_n_in <= 1'b1;
    axr(REG_CTRL, rd, rs);
    chk({rs, rd}, {RESP_OKAY, 30'h0, CTRL_RESET}, "ctrl reset");
    chk(cmd_ready_out, 1'b1, "ready after reset");
    mc_en <= 1'b1;
    run(8'd10, 33'h0_1000_00C0, 33'h20, 33'h0_1000_0000, 33'h0_1000_0140, 1'b0, 1'b1, 2'h1);
    ctrl_q = 2'h1;
    axw(REG_CTRL, 32'h1, rs);
    chk(rs, RESP_OKAY, "ctrl write");
    run(8'd70, 33'h0_8000_0000, 33'h0, 33'h0_8000_0000, 33'h1_FFFF_0000, 1'b1, 1'b1, 2'h0);
    // The queue is filled with the controller stalled, then drained with reordering enabled.
    ctrl_q = 2'h3;
    axw(REG_CTRL, 32'h3, rs);
    mc_en <= 1'b0;
    fork
      run(8'd20, 33'h0, 33'h0, 33'h0, 33'h0_0000_0100, 1'b1, 1'b1, 2'h0);
      begin
        while (cmd_ready_out !== 1'b0) @(posedge core_clk_in);
        repeat (4) @(posedge core_clk_in);
        chk(q.size() >= Q_DEPTH, 1'b1, "fill");
        axr(REG_STATUS, rd, rs);
        chk(rd[3:0], Q_DEPTH_C, "status fill");
        mc_en <= 1'b1;
      end
    join
    unal <= 1'b1;
    run(8'd16, 33'h0, 33'h0, 33'h0, 33'h0_0000_0100, 1'b1, 1'b0, 2'h0);
    axw(REG_ISSUED, lfsr_q, rs);
    chk(rs, RESP_OKAY, "read-only write");
    axr(REG_ISSUED, rd, rs);
    chk(rd, n_iss, "issued count");
    axr(REG_LAST_ROUTE, rd, rs);
    chk(rd, last_q, "last route");
    axw(8'h10, lfsr_q, rs);
    chk(rs, RESP_SLVERR, "unmapped write");
    axr(8'h10, rd, rs);
    chk({rs, rd}, {RESP_SLVERR, 32'h0}, "unmapped read");
    finish_test();
  end
endmodule : tb_top
